// [design/sleep_ctrl_pkg.sv]
// constants for the sleep-mode controller
package sleep_ctrl_pkg;
    localparam logic [3:0] addr_power_control = 4'h0;
    localparam logic [3:0] addr_wake_enable = 4'h4;
    localparam logic [3:0] addr_status = 4'h8;
    localparam logic [3:0] addr_timing = 4'hc;
    localparam int sleep_permit_pos = 7;
    localparam int mode_lsb = 4;
    localparam logic [7:0] power_control_reset = 8'h00;
    localparam logic [2:0] mode_idle = 3'h0;
    localparam logic [2:0] mode_adc_nr = 3'h1;
    localparam logic [2:0] mode_pdown = 3'h2;
    localparam logic [2:0] mode_psave = 3'h3;
    localparam logic [2:0] mode_standby = 3'h6;
    localparam int halt_extra_cycles = 4;
    localparam int standby_wake_cycles = 6;
    localparam logic [15:0] startup_reset = 16'h0006;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// [design/sleep_mode_controller.sv]
// sleep-mode controller: mode decode, clock gating, wake selection, wake delay
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module sleep_mode_controller #(
    parameter int startup_width = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_instr,
    input wire logic core_reset,
    input wire logic crystal_selected,
    input wire logic timer2_async_select,
    input wire logic global_irq_enable,
    input wire logic adc_enabled,
    input wire logic any_irq,
    input wire logic adc_done_irq,
    input wire logic twi_match_irq,
    input wire logic timer2_ovf_irq,
    input wire logic timer2_cmp_irq,
    input wire logic timer2_ovf_ie,
    input wire logic timer2_cmp_ie,
    input wire logic spm_ready_irq,
    input wire logic ext_irq_line_a,
    input wire logic ext_irq_line_b,
    input wire logic ext_a_is_level,
    input wire logic ext_b_is_level,
    output logic cpu_halt,
    output logic resume_irq,
    output logic resume_reset,
    output logic clk_cpu_en,
    output logic clk_flash_en,
    output logic clk_io_en,
    output logic clk_adc_en,
    output logic clk_asy_en,
    output logic main_osc_en,
    output logic timer_osc_en,
    output logic adc_start
);
    typedef enum logic [2:0] {st_run, st_sleep, st_startup, st_halt} state_e;

    state_e state;
    logic [7:0] mcu_power_control;
    logic [2:0] active_mode;
    logic [startup_width-1:0] startup_cycles;
    logic [startup_width-1:0] wait_count;
    logic wake_is_reset;
    logic wr_addr_ok, wr_data_ok;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic mode_legal, enter_sleep, wake_irq, wake_reset;

    function automatic logic legal_mode(input logic [2:0] m, input logic xtal);
        case (m)
            sleep_ctrl_pkg::mode_idle, sleep_ctrl_pkg::mode_adc_nr,
            sleep_ctrl_pkg::mode_pdown, sleep_ctrl_pkg::mode_psave: legal_mode = 1'b1;
            sleep_ctrl_pkg::mode_standby: legal_mode = xtal;
            default: legal_mode = 1'b0;
        endcase
    endfunction

    // register writes
    assign s_axi_awready = !wr_addr_ok && !s_axi_bvalid;
    assign s_axi_wready = !wr_data_ok && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_addr_ok <= 1'b0;
            wr_data_ok <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sleep_ctrl_pkg::resp_okay;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                wr_addr_ok <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wr_data_ok <= 1'b1;
                wr_data <= s_axi_wdata;
            end
            if (wr_addr_ok && wr_data_ok)
            begin
                wr_addr_ok <= 1'b0;
                wr_data_ok <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr == sleep_ctrl_pkg::addr_power_control ||
                                wr_addr == sleep_ctrl_pkg::addr_timing)
                               ? sleep_ctrl_pkg::resp_okay : sleep_ctrl_pkg::resp_slverr;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    logic [3:0] held_strb;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            held_strb <= 4'h0;
        else if (s_axi_wvalid && s_axi_wready)
            held_strb <= s_axi_wstrb;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mcu_power_control <= sleep_ctrl_pkg::power_control_reset;
            startup_cycles <= startup_width'(sleep_ctrl_pkg::startup_reset);
        end
        else if (wr_addr_ok && wr_data_ok)
        begin
            if (wr_addr == sleep_ctrl_pkg::addr_power_control && held_strb[0])
                mcu_power_control <= wr_data[7:0];
            if (wr_addr == sleep_ctrl_pkg::addr_timing && held_strb[0])
                startup_cycles <= wr_data[startup_width-1:0];
        end
    end

    // register reads
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= sleep_ctrl_pkg::resp_okay;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= sleep_ctrl_pkg::resp_okay;
            case (s_axi_araddr)
                sleep_ctrl_pkg::addr_power_control: s_axi_rdata <= {24'h0, mcu_power_control};
                sleep_ctrl_pkg::addr_status: s_axi_rdata <= {25'h0, active_mode, 1'b0,
                                                            3'(state)};
                sleep_ctrl_pkg::addr_timing: s_axi_rdata <= 32'(startup_cycles);
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= sleep_ctrl_pkg::resp_slverr;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // sleep entry
    assign mode_legal = legal_mode(mcu_power_control[sleep_ctrl_pkg::mode_lsb +: 3],
                                   crystal_selected);
    assign enter_sleep = state == st_run && sleep_instr && mode_legal &&
                         mcu_power_control[sleep_ctrl_pkg::sleep_permit_pos];

    // wake source selection per mode
    logic ext_level_wake, t2_wake;
    assign ext_level_wake = (ext_irq_line_a && ext_a_is_level) ||
                            (ext_irq_line_b && ext_b_is_level);
    assign t2_wake = timer2_async_select && global_irq_enable &&
                     ((timer2_ovf_irq && timer2_ovf_ie) ||
                      (timer2_cmp_irq && timer2_cmp_ie));

    always_comb
    begin
        case (active_mode)
            sleep_ctrl_pkg::mode_idle: wake_irq = any_irq;
            sleep_ctrl_pkg::mode_adc_nr: wake_irq = adc_done_irq || twi_match_irq ||
                timer2_ovf_irq || timer2_cmp_irq || spm_ready_irq || ext_level_wake;
            sleep_ctrl_pkg::mode_psave: wake_irq = twi_match_irq || ext_level_wake ||
                t2_wake;
            default: wake_irq = twi_match_irq || ext_level_wake;
        endcase
    end
    assign wake_reset = core_reset;

    // sequencer; storage is untouched, only clocks are gated
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= st_run;
            active_mode <= sleep_ctrl_pkg::mode_idle;
            wait_count <= '0;
            wake_is_reset <= 1'b0;
        end
        else
        begin
            case (state)
                st_run:
                begin
                    wake_is_reset <= 1'b0;
                    if (enter_sleep)
                    begin
                        state <= st_sleep;
                        active_mode <= mcu_power_control[sleep_ctrl_pkg::mode_lsb +: 3];
                    end
                end
                st_sleep:
                    if (wake_reset || wake_irq)
                    begin
                        wake_is_reset <= wake_reset;
                        // deep modes wait a start-up delay first: startup_cycles after pdown and psave, standby_wake_cycles after standby
                        case (active_mode)
                            sleep_ctrl_pkg::mode_pdown, sleep_ctrl_pkg::mode_psave:
                            begin
                                state <= st_startup;
                                wait_count <= startup_cycles;
                            end
                            sleep_ctrl_pkg::mode_standby:
                            begin
                                state <= st_startup;
                                wait_count <= startup_width'(sleep_ctrl_pkg::standby_wake_cycles);
                            end
                            default:
                            begin
                                state <= st_halt;
                                wait_count <= startup_width'(sleep_ctrl_pkg::halt_extra_cycles);
                            end
                        endcase
                    end
                st_startup:
                    if (wait_count <= 1)
                    begin
                        state <= st_halt;
                        wait_count <= startup_width'(sleep_ctrl_pkg::halt_extra_cycles);
                    end
                    else
                        wait_count <= wait_count - 1'b1;
                st_halt:
                    if (wait_count <= 1)
                        state <= st_run;
                    else
                        wait_count <= wait_count - 1'b1;
                default: state <= st_run;
            endcase
        end
    end

    // resume pulses and adc kick
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            resume_irq <= 1'b0;
            resume_reset <= 1'b0;
            adc_start <= 1'b0;
        end
        else
        begin
            resume_irq <= state == st_halt && wait_count <= 1 && !wake_is_reset;
            resume_reset <= state == st_halt && wait_count <= 1 && wake_is_reset;
            adc_start <= enter_sleep && adc_enabled &&
                         (mcu_power_control[sleep_ctrl_pkg::mode_lsb +: 3] ==
                          sleep_ctrl_pkg::mode_idle ||
                          mcu_power_control[sleep_ctrl_pkg::mode_lsb +: 3] ==
                          sleep_ctrl_pkg::mode_adc_nr);
        end
    end

    // clock domain gating; comparator power is left to software
    logic asleep;
    assign asleep = state == st_sleep || state == st_startup;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_halt <= 1'b0;
            clk_cpu_en <= 1'b1;
            clk_flash_en <= 1'b1;
            clk_io_en <= 1'b1;
            clk_adc_en <= 1'b1;
            clk_asy_en <= 1'b1;
            main_osc_en <= 1'b1;
            timer_osc_en <= 1'b0;
        end
        else
        begin
            cpu_halt <= state != st_run || enter_sleep;
            clk_cpu_en <= !(asleep || enter_sleep);
            clk_flash_en <= !(asleep || enter_sleep);
            clk_io_en <= !asleep || active_mode == sleep_ctrl_pkg::mode_idle;
            clk_adc_en <= !asleep || active_mode == sleep_ctrl_pkg::mode_idle ||
                          active_mode == sleep_ctrl_pkg::mode_adc_nr;
            clk_asy_en <= !asleep || ((active_mode == sleep_ctrl_pkg::mode_idle ||
                          active_mode == sleep_ctrl_pkg::mode_adc_nr ||
                          active_mode == sleep_ctrl_pkg::mode_psave) &&
                          timer2_async_select);
            main_osc_en <= state != st_sleep || active_mode == sleep_ctrl_pkg::mode_idle ||
                           active_mode == sleep_ctrl_pkg::mode_adc_nr ||
                           active_mode == sleep_ctrl_pkg::mode_standby;
            timer_osc_en <= timer2_async_select && (!asleep ||
                            active_mode != sleep_ctrl_pkg::mode_pdown &&
                            active_mode != sleep_ctrl_pkg::mode_standby);
        end
    end
endmodule

// [tb/sleep_ctrl_assertions.sv]
// port-level assertions for the sleep-mode controller
`timescale 1ns/100ps
module sleep_ctrl_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_instr,
    input wire logic core_reset,
    input wire logic timer2_async_select,
    input wire logic adc_enabled,
    input wire logic cpu_halt,
    input wire logic resume_irq,
    input wire logic resume_reset,
    input wire logic clk_cpu_en,
    input wire logic clk_io_en,
    input wire logic main_osc_en,
    input wire logic timer_osc_en,
    input wire logic adc_start
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_halt_from_sleep: assert property (!cpu_halt && !sleep_instr |=> !cpu_halt)
        else $error("halt without sleep instruction");
    a_resume_after_halt: assert property (resume_irq |-> $past(cpu_halt))
        else $error("resume while running");
    a_reset_wakes: assert property (cpu_halt && core_reset |-> ##[0:40] resume_reset)
        else $error("reset did not wake");
    a_reset_not_irq: assert property (resume_reset |-> !resume_irq)
        else $error("reset wake resumed as interrupt");
    a_adc_start_cause: assert property ($rose(adc_start) |-> $past(adc_enabled))
        else $error("conversion started with adc off");
    a_no_osc_clocks: assert property (!main_osc_en |-> !clk_io_en && !clk_cpu_en)
        else $error("clock running without oscillator");
    a_async_needs_sel: assert property (cpu_halt && timer_osc_en |->
        $past(timer2_async_select))
        else $error("timer oscillator on without async select");
    a_run_cpu_clock: assert property (!cpu_halt |-> clk_cpu_en)
        else $error("cpu clock stopped while running");
endmodule
bind sleep_mode_controller sleep_ctrl_assertions sleep_ctrl_assertions_inst (
    .aclk, .aresetn, .sleep_instr, .core_reset, .timer2_async_select, .adc_enabled,
    .cpu_halt, .resume_irq, .resume_reset, .clk_cpu_en, .clk_io_en, .main_osc_en,
    .timer_osc_en, .adc_start
);

// [tb/core_side_model.sv]
// core-side model: sleep instruction pulse and a held level wake line
`timescale 1ns/100ps
module core_side_model (
    input wire logic aclk,
    input wire logic go_sleep,
    input wire logic lvl_req,
    input wire logic resume_irq,
    input wire logic resume_reset,
    output logic sleep_instr = 1'b0,
    output logic ext_line = 1'b0
);
    logic req_q = 1'b0;
    always @(posedge aclk)
    begin
        sleep_instr <= go_sleep;
        req_q <= lvl_req;
        // level stays until the core resumes, a short glitch could go unseen
        if (lvl_req && !req_q)
            ext_line <= 1'b1;
        else if (resume_irq || resume_reset)
            ext_line <= 1'b0;
    end
endmodule

// [tb/tb_sleep_mode_controller.sv]
// self-checking bench for the sleep-mode controller
`timescale 1ns/100ps
module tb_sleep_mode_controller;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic core_reset = 1'b0, crystal_selected = 1'b0, timer2_async_select = 1'b0;
    logic global_irq_enable = 1'b1, adc_enabled = 1'b1, any_irq = 1'b0;
    logic adc_done_irq = 1'b0, twi_match_irq = 1'b0, timer2_ovf_irq = 1'b0;
    logic timer2_ovf_ie = 1'b0, timer2_cmp_irq = 1'b0, timer2_cmp_ie = 1'b0;
    logic spm_ready_irq = 1'b0, ext_irq_line_b = 1'b0, ext_a_is_level = 1'b1;
    logic ext_b_is_level = 1'b0, go_sleep = 1'b0, lvl_req = 1'b0;
    logic sleep_instr, ext_irq_line_a, cpu_halt, resume_irq, resume_reset;
    logic clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_asy_en;
    logic main_osc_en, timer_osc_en, adc_start, ad, dd;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [2:0] md [5] = '{sleep_ctrl_pkg::mode_idle, sleep_ctrl_pkg::mode_adc_nr,
        sleep_ctrl_pkg::mode_pdown, sleep_ctrl_pkg::mode_psave, sleep_ctrl_pkg::mode_standby};
    // expected {io, adc, oscillator} while asleep; timer2 asynchronous in psave only
    logic [2:0] ck [5] = '{3'h7, 3'h3, 3'h0, 3'h0, 3'h1};
    logic [7:0] refused [4] = '{8'h00, 8'hc0, 8'hd0, 8'he0};
    int miscompares = 0;
    int total_checks = 0;
    int n;
    int w;
    int starts = 0;
    sleep_mode_controller sleep_mode_controller_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr, .core_reset,
        .crystal_selected, .timer2_async_select, .global_irq_enable, .adc_enabled,
        .any_irq, .adc_done_irq, .twi_match_irq, .timer2_ovf_irq, .timer2_cmp_irq,
        .timer2_ovf_ie, .timer2_cmp_ie, .spm_ready_irq, .ext_irq_line_a, .ext_irq_line_b,
        .ext_a_is_level, .ext_b_is_level, .cpu_halt, .resume_irq, .resume_reset,
        .clk_cpu_en, .clk_flash_en, .clk_io_en, .clk_adc_en, .clk_asy_en, .main_osc_en,
        .timer_osc_en, .adc_start
    );
    core_side_model core_side_model_inst (
        .aclk, .go_sleep, .lvl_req, .resume_irq, .resume_reset, .sleep_instr,
        .ext_line(ext_irq_line_a)
    );
    initial
    begin
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk)
        if (adc_start === 1'b1)
            starts++;
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        ad = 1'b0;
        dd = 1'b0;
        while (!(ad && dd))
        begin
            @(posedge aclk);
            ad = ad || s_axi_awready;
            dd = dd || s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !dd;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check(rd === d && rr === r, "register read");
    endtask
    task automatic enter(input logic [7:0] v, input logic ok);
        wr(sleep_ctrl_pkg::addr_power_control, {24'h0, v});
        go_sleep <= 1'b1;
        @(posedge aclk);
        go_sleep <= 1'b0;
        repeat (4) @(posedge aclk);
        check(cpu_halt === ok, "sleep entry");
    endtask
    // g selects the proper wake source of mode i, else one that must not wake it (for mode 0, none)
    task automatic src(input int i, input logic g, input logic v);
        if (g)
            case (i)
                0: any_irq <= v;
                1: adc_done_irq <= v;
                2: lvl_req <= v;
                3: {timer2_ovf_irq, timer2_ovf_ie} <= {v, v};
                default: twi_match_irq <= v;
            endcase
        else
            case (i)
                0: any_irq <= 1'b0;
                1: ext_irq_line_b <= v;
                2: adc_done_irq <= v;
                3: timer2_ovf_irq <= v;
                4: any_irq <= v;
                default: ;
            endcase
    endtask
    task automatic wake_wait(input int a, input int b, input logic rst);
        n = 0;
        while (resume_irq !== 1'b1 && resume_reset !== 1'b1 && n < 60)
        begin
            @(posedge aclk);
            n++;
        end
        check(n >= a && n <= b && resume_reset === rst, "wake delay");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(sleep_ctrl_pkg::addr_power_control, 32'h0, sleep_ctrl_pkg::resp_okay);
        rchk(sleep_ctrl_pkg::addr_timing, {16'h0, sleep_ctrl_pkg::startup_reset},
            sleep_ctrl_pkg::resp_okay);
        rchk(sleep_ctrl_pkg::addr_wake_enable, 32'h0, sleep_ctrl_pkg::resp_slverr);
        wr(sleep_ctrl_pkg::addr_wake_enable, 32'h1);
        check(s_axi_bresp === sleep_ctrl_pkg::resp_slverr, "unmapped write");
        // no byte lane enabled: the write must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(sleep_ctrl_pkg::addr_power_control, 32'h80);
        s_axi_wstrb <= 4'h1;
        rchk(sleep_ctrl_pkg::addr_power_control, 32'h0, sleep_ctrl_pkg::resp_okay);
        $display("test registers done");
        // no permit, two reserved codes, standby without crystal
        foreach (refused[k])
            enter(refused[k], 1'b0);
        $display("test refused entry done");
        crystal_selected <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            w = sleep_ctrl_pkg::halt_extra_cycles;
            if (i > 1)
                w += (i == 4) ? sleep_ctrl_pkg::standby_wake_cycles
                    : int'(sleep_ctrl_pkg::startup_reset);
            timer2_async_select <= (i == 3);
            enter({1'b1, md[i], 4'h0}, 1'b1);
            check({clk_cpu_en, clk_flash_en} === 2'h0, "cpu clocks");
            check({clk_io_en, clk_adc_en, main_osc_en} === ck[i],
                "domains");
            check({clk_asy_en, timer_osc_en} === {2{i == 3}}, "async domain");
            src(i, 1'b0, 1'b1);
            repeat (8) @(posedge aclk);
            check(cpu_halt === 1'b1, "wrong wake source");
            src(i, 1'b0, 1'b0);
            @(posedge aclk);
            src(i, 1'b1, 1'b1);
            wake_wait(w, w + 4, 1'b0);
            src(i, 1'b1, 1'b0);
            rchk(sleep_ctrl_pkg::addr_power_control, {24'h0, 1'b1, md[i], 4'h0},
                sleep_ctrl_pkg::resp_okay);
            // status: mode entered, state field back to run (zero)
            rchk(sleep_ctrl_pkg::addr_status, {25'h0, md[i], 4'h0},
                sleep_ctrl_pkg::resp_okay);
        end
        check(starts === 2, "conversion starts");
        $display("test modes done");
        wr(sleep_ctrl_pkg::addr_timing, 32'h9);
        rchk(sleep_ctrl_pkg::addr_timing, 32'h9, sleep_ctrl_pkg::resp_okay);
        w = sleep_ctrl_pkg::halt_extra_cycles + 9;
        enter({1'b1, sleep_ctrl_pkg::mode_pdown, 4'h0}, 1'b1);
        core_reset <= 1'b1;
        wake_wait(w, w + 4, 1'b1);
        core_reset <= 1'b0;
        $display("test reset wake done");
        complete_run();
    end
endmodule
